// ### inc/fifo_if.sv
`timescale 1ns/1ns
`default_nettype none
// valid/ready word channel into a buffer from the register side, or out of it to the transmitter
interface fifo_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : fifo_if
`default_nettype wire

// ### inc/serial_pkg.sv
package serial_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RATE0 = 8'h87;
  localparam logic [7:0] ADDR_CLOCK_RATE = 8'h8E;
  localparam logic [7:0] ADDR_CTRL0 = 8'h98;
  localparam logic [7:0] ADDR_BUF0 = 8'h99;
  localparam logic [7:0] ADDR_CTRL1 = 8'hC0;
  localparam logic [7:0] ADDR_BUF1 = 8'hC1;
  localparam logic [7:0] ADDR_WT_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] ADDR_ACTIVATION = 8'hD7;
  localparam logic [7:0] ADDR_RATE1 = 8'hD8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_DOUBLER = 7;
  localparam int BIT_WT_RATE = 5;
  localparam int BIT_MODE_A = 7;
  localparam int BIT_MODE_B = 6;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam int BIT_WT_OVF = 7;
  localparam int BIT_RX_CLK_SEL = 5;
  localparam int BIT_TX_CLK_SEL = 4;
  localparam int BIT_WT_RUN = 2;
  localparam int BIT_WT_COUNTER = 1;
  localparam int BIT_RELOAD_DIS = 0;
  localparam int BIT_PORT1_ACT = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;

  // ----------------------------------------------------------------
  // serial modes and timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_1 = 2'b01;
  localparam logic [1:0] MODE_2 = 2'b10;
  localparam logic [1:0] MODE_3 = 2'b11;
  localparam logic [3:0] WT_STEP_FAST = 4'd4;
  localparam logic [3:0] WT_STEP_SLOW = 4'd12;
  localparam logic [3:0] WT_STEP_BAUD = 4'd2;
  localparam logic [3:0] M2_STEP_FAST = 4'd2;
  localparam logic [3:0] M2_STEP_SLOW = 4'd4;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'd15;
  localparam logic [3:0] SAMPLE_DECIDE = 4'd10;
  localparam logic [3:0] LAST_RX_BIT = 4'd9;
  localparam logic [3:0] TX_BITS_MODE1 = 4'd9;
  localparam logic [3:0] TX_BITS_NINE = 4'd10;

  typedef enum logic {LINE_IDLE, LINE_BUSY} line_state_t;

endpackage : serial_pkg

// ### verif/dual_serial_timer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dual_serial_timer_properties (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  input wire logic PORT0_TRANSMIT_PIN,
  input wire logic PORT1_TRANSMIT_PIN,
  input wire logic [1:0] TX_BUFFER_READY,
  input wire logic WIDE_TIMER_REQUEST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire logic wr_ctl = SFR_WR && SFR_ADDR == serial_pkg::ADDR_WT_CTRL;
  logic baud_reg;
  logic [7:0] high_reg;
  // shadow of the clock selects; the flag may only rise outside baud mode or on a software write of bit 7
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
      baud_reg <= 1'b0;
    else if (wr_ctl)
      baud_reg <= |SFR_WDATA[5:4];
  // shadow of the reload high byte
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
      high_reg <= 8'h00;
    else if (SFR_WR && SFR_ADDR == serial_pkg::ADDR_RELOAD_HIGH)
      high_reg <= SFR_WDATA;
  property p_hold; !SFR_RD |=> $stable(SFR_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmapped; SFR_RD && SFR_ADDR == 8'h00 |=> SFR_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_flag; SFR_RD && SFR_ADDR == serial_pkg::ADDR_WT_CTRL |=> SFR_RDATA[7] == $past(WIDE_TIMER_REQUEST); endproperty
  a_flag: assert property (p_flag) else $error("flag read differs");
  property p_baud; $rose(WIDE_TIMER_REQUEST) |-> !baud_reg || $past(wr_ctl && SFR_WDATA[7]); endproperty
  a_baud: assert property (p_baud) else $error("flag set in baud mode");
  property p_reload; SFR_RD && SFR_ADDR == serial_pkg::ADDR_RELOAD_HIGH |=> SFR_RDATA == $past(high_reg); endproperty
  a_reload: assert property (p_reload) else $error("reload high lost");
  property p_start0; $fell(PORT0_TRANSMIT_PIN) |=> (!PORT0_TRANSMIT_PIN) [*8]; endproperty
  a_start0: assert property (p_start0) else $error("port0 start bit short");
  property p_start1; $fell(PORT1_TRANSMIT_PIN) |-> ##1 $stable(PORT1_TRANSMIT_PIN) [*8]; endproperty
  a_start1: assert property (p_start1) else $error("port1 start bit short");
  property p_full; $fell(TX_BUFFER_READY[1]) |-> $past(SFR_WR && SFR_ADDR == serial_pkg::ADDR_BUF1); endproperty
  a_full: assert property (p_full) else $error("ready fell without write");
endmodule : dual_serial_timer_properties
`default_nettype wire

// ### verif/remote_serial.sv
`timescale 1ns/1ns
`default_nettype none
module remote_serial #(
  parameter int BIT_CLKS = 64
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got;
  int frames = 0;
  initial line_out = 1'b1;
  // catcher samples bit centres; a bad stop bit is not counted
  always @(negedge line_in)
  begin
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      got[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk);
    if (line_in) frames++;
  end
  // start, data lsb first, stop; line idles high after
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out = f[i];
      repeat (BIT_CLKS) @(posedge clk);
      #1;
    end
  endtask : send
endmodule : remote_serial
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ovf = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [1:0] ready;
  logic tx0, tx1, rx0, rx1, wreq;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  always #10 clk = ~clk;
  // narrow overflow pulses every second clock, so a bit lasts 64 clocks
  always @(posedge clk) #1 ovf = ~ovf;
  dual_serial_timer uut (.CLK(clk), .NRST(nrst), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_RDATA(rdata), .NARROW_TIMER_OVERFLOW(ovf), .PORT0_RECEIVE_PIN(rx0), .PORT1_RECEIVE_PIN(rx1),
    .PORT0_TRANSMIT_PIN(tx0), .PORT1_TRANSMIT_PIN(tx1), .TX_BUFFER_READY(ready), .WIDE_TIMER_REQUEST(wreq));
  remote_serial #(.BIT_CLKS(64)) far (.clk(clk), .line_in(tx0), .line_out(rx0));
  remote_serial #(.BIT_CLKS(64)) far1 (.clk(clk), .line_in(tx1), .line_out(rx1));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd_chk
  task automatic frame(input int k, input logic [7:0] exp);
    for (n = 0; n < 3000 && far.frames < k; n++) @(posedge clk) #1;
    chk("frames0", 8'(k), 8'(far.frames));
    chk("frame", exp, far.got);
  endtask : frame
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // main sequence: baud-mode link, port 1 link, then plain auto-reload timer
  initial
  begin
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    rd_chk(8'hC8, 8'h00);
    rd_chk(8'h00, 8'h00);
    wr_reg(8'hCA, 8'hFF);
    wr_reg(8'hCB, 8'hFE);
    wr_reg(8'hCC, 8'hFE);
    wr_reg(8'hCD, 8'hFF);
    rd_chk(8'hCA, 8'hFF);
    // reload disable set: baud mode must still reload
    wr_reg(8'hC8, 8'h35);
    wr_reg(8'hD7, 8'h00);
    wr_reg(8'h98, 8'h50);
    wr_reg(8'hC0, 8'h40);
    wr_reg(8'h99, 8'hA5);
    wr_reg(8'h99, 8'h3C);
    repeat (17) wr_reg(8'hC1, 8'h81);
    chk("ready1", 8'h00, {7'h00, ready[1]});
    frame(1, 8'hA5);
    frame(2, 8'h3C);
    rd_chk(8'h98, 8'h52);
    rd_chk(8'hC8, 8'h35);
    far.send(8'h96);
    rd_chk(8'h98, 8'h57);
    rd_chk(8'h99, 8'h96);
    far.send(8'h3C);
    rd_chk(8'h99, 8'h96);
    wr_reg(8'h98, 8'h40);
    far.send(8'h0F);
    rd_chk(8'h98, 8'h40);
    // port 1 drains sixteen words, the seventeenth was dropped
    for (n = 0; n < 12000 && far1.frames < 16; n++) @(posedge clk) #1;
    chk("frames1", 8'h10, 8'(far1.frames));
    chk("frame1", 8'h81, far1.got);
    rd_chk(8'hC0, 8'h42);
    wr_reg(8'hC0, 8'h50);
    far1.send(8'h5A);
    rd_chk(8'hC0, 8'h55);
    rd_chk(8'hC1, 8'h5A);
    wr_reg(8'hC8, 8'h00);
    wr_reg(8'h8E, 8'h20);
    wr_reg(8'hCB, 8'h00);
    wr_reg(8'hCA, 8'h12);
    wr_reg(8'hCC, 8'hFE);
    wr_reg(8'hCD, 8'hFF);
    wr_reg(8'hC8, 8'h04);
    for (n = 0; n < 40 && wreq !== 1'b1; n++) @(posedge clk) #1;
    chk("overflow time", 8'h01, {7'h00, n >= 4 && n <= 10});
    rd_chk(8'hC8, 8'h84);
    wr_reg(8'hC8, 8'h00);
    rd_chk(8'hCD, 8'h12);
    end_of_test();
  end
  // watchdog well beyond the expected run of about 12000 clocks
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule : tb
bind dual_serial_timer dual_serial_timer_properties chk_i (.CLK(CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
  .PORT0_TRANSMIT_PIN(PORT0_TRANSMIT_PIN), .PORT1_TRANSMIT_PIN(PORT1_TRANSMIT_PIN),
  .TX_BUFFER_READY(TX_BUFFER_READY), .WIDE_TIMER_REQUEST(WIDE_TIMER_REQUEST));
`default_nettype wire

// ### verilog/dual_serial_timer.sv
`timescale 1ns/1ns
`default_nettype none
module dual_serial_timer #(
  parameter int TX_DEPTH = 16
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  input wire logic NARROW_TIMER_OVERFLOW,
  input wire logic PORT0_RECEIVE_PIN,
  input wire logic PORT1_RECEIVE_PIN,
  output logic PORT0_TRANSMIT_PIN,
  output logic PORT1_TRANSMIT_PIN,
  output logic [1:0] TX_BUFFER_READY,
  output logic WIDE_TIMER_REQUEST
);
  if (TX_DEPTH < 2)
  begin : bad_depth
    $error("transmit buffer depth must be at least 2");
  end

  // ----------------------------------------------------------------
  // shared registers
  // ----------------------------------------------------------------
  logic [7:0] rate0_reg;
  logic [7:0] rate1_reg;
  logic [7:0] clock_rate_reg;
  logic [7:0] wt_ctrl_reg;
  logic [7:0] reload_high_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] activation_reg;
  logic [15:0] count_reg;
  logic [3:0] wt_pre_reg;
  logic [3:0] m2_pre_reg;
  logic [7:0] ctrl_reg [2];
  logic [7:0] hold_reg [2];
  logic [1:0] port_tx_out;
  logic [1:0] rx_pin;
  logic [1:0] doubler;
  logic wr_ctrl_wt;
  logic baud_mode;
  logic wt_step;
  logic wt_ovf;
  logic t2_pulse;
  logic [3:0] wt_div;
  logic m2_tick;

  assign wr_ctrl_wt = SFR_WR && SFR_ADDR == serial_pkg::ADDR_WT_CTRL;
  assign rx_pin = {PORT1_RECEIVE_PIN, PORT0_RECEIVE_PIN};
  assign doubler = {rate1_reg[serial_pkg::BIT_DOUBLER], rate0_reg[serial_pkg::BIT_DOUBLER]};

  // plain configuration registers; flag bits are handled separately
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rate0_reg <= serial_pkg::RESET_BYTE;
      rate1_reg <= serial_pkg::RESET_BYTE;
      clock_rate_reg <= serial_pkg::RESET_BYTE;
      reload_high_reg <= serial_pkg::RESET_BYTE;
      reload_low_reg <= serial_pkg::RESET_BYTE;
      activation_reg <= serial_pkg::RESET_BYTE;
    end
    else if (SFR_WR)
    begin
      case (SFR_ADDR)
        serial_pkg::ADDR_RATE0: rate0_reg <= SFR_WDATA;
        serial_pkg::ADDR_RATE1: rate1_reg <= SFR_WDATA;
        serial_pkg::ADDR_CLOCK_RATE: clock_rate_reg <= SFR_WDATA;
        serial_pkg::ADDR_RELOAD_HIGH: reload_high_reg <= SFR_WDATA;
        serial_pkg::ADDR_RELOAD_LOW: reload_low_reg <= SFR_WDATA;
        serial_pkg::ADDR_ACTIVATION: activation_reg <= SFR_WDATA;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wide timer
  // ----------------------------------------------------------------
  // the counter select bit is stored but ignored: only the system clock counts
  assign baud_mode = (wt_ctrl_reg[serial_pkg::BIT_RX_CLK_SEL] || wt_ctrl_reg[serial_pkg::BIT_TX_CLK_SEL])
                   && wt_ctrl_reg[serial_pkg::BIT_WT_RUN];
  always_comb
  begin
    if (baud_mode)
      wt_div = serial_pkg::WT_STEP_BAUD;
    else if (clock_rate_reg[serial_pkg::BIT_WT_RATE])
      wt_div = serial_pkg::WT_STEP_FAST;
    else
      wt_div = serial_pkg::WT_STEP_SLOW;
  end
  assign wt_step = wt_ctrl_reg[serial_pkg::BIT_WT_RUN] && wt_pre_reg >= wt_div - 4'd1;
  assign wt_ovf = wt_step && count_reg == serial_pkg::COUNT_TOP;
  assign t2_pulse = wt_ovf && baud_mode;

  // prescaler; restarts when stopped so the first step is a full period
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      wt_pre_reg <= 4'd0;
    else if (!wt_ctrl_reg[serial_pkg::BIT_WT_RUN] || wt_step)
      wt_pre_reg <= 4'd0;
    else
      wt_pre_reg <= wt_pre_reg + 4'd1;
  end

  // count; a software write to a count byte wins over a step
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      count_reg <= 16'h0000;
    else if (SFR_WR && SFR_ADDR == serial_pkg::ADDR_COUNT_LOW)
      count_reg[7:0] <= SFR_WDATA;
    else if (SFR_WR && SFR_ADDR == serial_pkg::ADDR_COUNT_HIGH)
      count_reg[15:8] <= SFR_WDATA;
    else if (wt_ovf && (baud_mode || wt_ctrl_reg[serial_pkg::BIT_RX_CLK_SEL]
             || wt_ctrl_reg[serial_pkg::BIT_TX_CLK_SEL] || !wt_ctrl_reg[serial_pkg::BIT_RELOAD_DIS]))
      count_reg <= {reload_high_reg, reload_low_reg};
    else if (wt_step)
      count_reg <= count_reg + 16'h0001;
  end

  // control register; overflow set beats a software clear in the same cycle
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      wt_ctrl_reg <= serial_pkg::RESET_BYTE;
    else
    begin
      if (wr_ctrl_wt)
        wt_ctrl_reg <= SFR_WDATA;
      if (wt_ovf && !baud_mode)
        wt_ctrl_reg[serial_pkg::BIT_WT_OVF] <= 1'b1;
    end
  end
  assign WIDE_TIMER_REQUEST = wt_ctrl_reg[serial_pkg::BIT_WT_OVF];

  // mode 2 oversample tick: clk/2 or clk/4 gives bit rate clk/32 or clk/64
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      m2_pre_reg <= 4'd0;
    else if (m2_tick)
      m2_pre_reg <= 4'd0;
    else
      m2_pre_reg <= m2_pre_reg + 4'd1;
  end
  assign m2_tick = m2_pre_reg >= (doubler[0] ? serial_pkg::M2_STEP_FAST : serial_pkg::M2_STEP_SLOW) - 4'd1;

  // ----------------------------------------------------------------
  // serial ports
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : port
    localparam logic [7:0] CTRL_ADDR = (p == 0) ? serial_pkg::ADDR_CTRL0 : serial_pkg::ADDR_CTRL1;
    localparam logic [7:0] BUF_ADDR = (p == 0) ? serial_pkg::ADDR_BUF0 : serial_pkg::ADDR_BUF1;
    fifo_if #(.WIDTH(8)) fill_ch ();
    fifo_if #(.WIDTH(8)) drain_ch ();
    logic [1:0] mode;
    logic active;
    logic half_reg;
    logic narrow_tick;
    logic tx_tick;
    logic rx_tick;
    logic tx_set;
    logic rx_set;
    logic ninth_now;
    logic line_level;
    logic line_prev_reg;
    logic maj;
    logic accept;
    serial_pkg::line_state_t tx_state_reg;
    serial_pkg::line_state_t rx_state_reg;
    logic [3:0] tx_div_reg;
    logic [3:0] tx_left_reg;
    logic [9:0] tx_shift_reg;
    logic [3:0] rx_div_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_data_reg;

    // port 1 only runs while its activation bit is cleared
    assign active = (p == 0) || !activation_reg[serial_pkg::BIT_PORT1_ACT];
    assign mode = {ctrl_reg[p][serial_pkg::BIT_MODE_A], ctrl_reg[p][serial_pkg::BIT_MODE_B]};

    // narrow timer overflow halved unless the rate doubler is set
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
        half_reg <= 1'b0;
      else if (NARROW_TIMER_OVERFLOW)
        half_reg <= ~half_reg;
    end
    assign narrow_tick = NARROW_TIMER_OVERFLOW && (doubler[p] || half_reg);

    // oversample ticks per direction; wide timer only reaches port 0
    always_comb
    begin
      tx_tick = 1'b0;
      rx_tick = 1'b0;
      case (mode)
        serial_pkg::MODE_2:
        begin
          tx_tick = m2_tick;
          rx_tick = m2_tick;
        end
        serial_pkg::MODE_1, serial_pkg::MODE_3:
        begin
          tx_tick = (p == 0 && wt_ctrl_reg[serial_pkg::BIT_TX_CLK_SEL]) ? t2_pulse : narrow_tick;
          rx_tick = (p == 0 && wt_ctrl_reg[serial_pkg::BIT_RX_CLK_SEL]) ? t2_pulse : narrow_tick;
        end
        default: ;
      endcase
      tx_tick = tx_tick && active;
      rx_tick = rx_tick && active;
    end

    // buffer writes feed the transmit FIFO; a full FIFO drops the write
    assign fill_ch.valid = SFR_WR && SFR_ADDR == BUF_ADDR;
    assign fill_ch.data = SFR_WDATA;
    assign TX_BUFFER_READY[p] = fill_ch.ready;

    sync_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) tx_fifo (
      .clk(CLK),
      .nrst(NRST),
      .fill(fill_ch.sink),
      .drain(drain_ch.source)
    );

    // ---------------- transmitter ----------------
    assign drain_ch.ready = tx_state_reg == serial_pkg::LINE_IDLE && tx_tick
                         && tx_div_reg == serial_pkg::OVERSAMPLE_LAST;
    assign ninth_now = (mode == serial_pkg::MODE_1) ? 1'b1 : ctrl_reg[p][serial_pkg::BIT_TX_NINTH];
    assign tx_set = tx_state_reg == serial_pkg::LINE_BUSY && tx_tick
                 && tx_div_reg == serial_pkg::OVERSAMPLE_LAST && tx_left_reg == 4'd1;

    // divide by 16; frames start on a rollover while the buffer holds a word
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
        tx_div_reg <= 4'd0;
      else if (tx_tick)
        tx_div_reg <= tx_div_reg + 4'd1;
    end

    // shift out start, data lsb first, ninth bit if any, then stop
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
      begin
        tx_state_reg <= serial_pkg::LINE_IDLE;
        tx_left_reg <= 4'd0;
        tx_shift_reg <= '1;
        port_tx_out[p] <= 1'b1;
      end
      else if (tx_tick && tx_div_reg == serial_pkg::OVERSAMPLE_LAST)
      begin
        case (tx_state_reg)
          serial_pkg::LINE_IDLE:
            if (drain_ch.valid)
            begin
              port_tx_out[p] <= 1'b0;
              tx_shift_reg <= {1'b1, ninth_now, drain_ch.data};
              tx_left_reg <= (mode == serial_pkg::MODE_1) ? serial_pkg::TX_BITS_MODE1 : serial_pkg::TX_BITS_NINE;
              tx_state_reg <= serial_pkg::LINE_BUSY;
            end
          serial_pkg::LINE_BUSY:
            if (tx_left_reg == 4'd0)
              tx_state_reg <= serial_pkg::LINE_IDLE;
            else
            begin
              port_tx_out[p] <= tx_shift_reg[0];
              tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
              tx_left_reg <= tx_left_reg - 4'd1;
            end
          default: tx_state_reg <= serial_pkg::LINE_IDLE;
        endcase
      end
    end

    // ---------------- receiver ----------------
    rx_sampler sampler (
      .clk(CLK),
      .nrst(NRST),
      .pin(rx_pin[p]),
      .tick(rx_tick),
      .level(line_level),
      .majority(maj)
    );

    // previous synchronised level for falling-edge search
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
        line_prev_reg <= 1'b1;
      else
        line_prev_reg <= line_level;
    end

    // last bit is the stop bit in mode 1 and the ninth bit in modes 2 and 3
    assign accept = !ctrl_reg[p][serial_pkg::BIT_RX_DONE]
                 && (!ctrl_reg[p][serial_pkg::BIT_MULTIPROC] || maj);
    assign rx_set = rx_state_reg == serial_pkg::LINE_BUSY && rx_tick
                 && rx_div_reg == serial_pkg::SAMPLE_DECIDE && rx_bit_reg == serial_pkg::LAST_RX_BIT && accept;

    // decision sits after samples 7, 8 and 9 of each bit
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
      begin
        rx_state_reg <= serial_pkg::LINE_IDLE;
        rx_div_reg <= 4'd0;
        rx_bit_reg <= 4'd0;
        rx_data_reg <= serial_pkg::RESET_BYTE;
      end
      else
      begin
        case (rx_state_reg)
          serial_pkg::LINE_IDLE:
            if (ctrl_reg[p][serial_pkg::BIT_RX_ENABLE] && active && line_prev_reg && !line_level)
            begin
              rx_div_reg <= 4'd0;
              rx_bit_reg <= 4'd0;
              rx_state_reg <= serial_pkg::LINE_BUSY;
            end
          serial_pkg::LINE_BUSY:
            if (!ctrl_reg[p][serial_pkg::BIT_RX_ENABLE] || !active)
              rx_state_reg <= serial_pkg::LINE_IDLE;
            else if (rx_tick)
            begin
              rx_div_reg <= rx_div_reg + 4'd1;
              if (rx_div_reg == serial_pkg::OVERSAMPLE_LAST)
                rx_bit_reg <= rx_bit_reg + 4'd1;
              if (rx_div_reg == serial_pkg::SAMPLE_DECIDE)
              begin
                if (rx_bit_reg == 4'd0 && maj)
                  rx_state_reg <= serial_pkg::LINE_IDLE;
                else if (rx_bit_reg == serial_pkg::LAST_RX_BIT)
                  rx_state_reg <= serial_pkg::LINE_IDLE;
                else if (rx_bit_reg != 4'd0)
                  rx_data_reg <= {maj, rx_data_reg[7:1]};
              end
            end
          default: rx_state_reg <= serial_pkg::LINE_IDLE;
        endcase
      end
    end

    // holding register keeps the word while the next one shifts in
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
        hold_reg[p] <= serial_pkg::RESET_BYTE;
      else if (rx_set)
        hold_reg[p] <= rx_data_reg;
    end

    // control register; hardware sets of the done flags win over clears
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
        ctrl_reg[p] <= serial_pkg::RESET_BYTE;
      else
      begin
        if (SFR_WR && SFR_ADDR == CTRL_ADDR)
          ctrl_reg[p] <= SFR_WDATA;
        if (rx_set)
        begin
          ctrl_reg[p][serial_pkg::BIT_RX_NINTH] <= maj;
          ctrl_reg[p][serial_pkg::BIT_RX_DONE] <= 1'b1;
        end
        if (tx_set)
          ctrl_reg[p][serial_pkg::BIT_TX_DONE] <= 1'b1;
      end
    end
  end

  assign PORT0_TRANSMIT_PIN = port_tx_out[0];
  assign PORT1_TRANSMIT_PIN = port_tx_out[1];

  // ----------------------------------------------------------------
  // register read port, one cycle latency, no read side effects
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      SFR_RDATA <= serial_pkg::RESET_BYTE;
    else if (SFR_RD)
    begin
      case (SFR_ADDR)
        serial_pkg::ADDR_RATE0: SFR_RDATA <= rate0_reg;
        serial_pkg::ADDR_RATE1: SFR_RDATA <= rate1_reg;
        serial_pkg::ADDR_CLOCK_RATE: SFR_RDATA <= clock_rate_reg;
        serial_pkg::ADDR_CTRL0: SFR_RDATA <= ctrl_reg[0];
        serial_pkg::ADDR_CTRL1: SFR_RDATA <= ctrl_reg[1];
        serial_pkg::ADDR_BUF0: SFR_RDATA <= hold_reg[0];
        serial_pkg::ADDR_BUF1: SFR_RDATA <= hold_reg[1];
        serial_pkg::ADDR_WT_CTRL: SFR_RDATA <= wt_ctrl_reg;
        serial_pkg::ADDR_RELOAD_HIGH: SFR_RDATA <= reload_high_reg;
        serial_pkg::ADDR_RELOAD_LOW: SFR_RDATA <= reload_low_reg;
        serial_pkg::ADDR_COUNT_LOW: SFR_RDATA <= count_reg[7:0];
        serial_pkg::ADDR_COUNT_HIGH: SFR_RDATA <= count_reg[15:8];
        serial_pkg::ADDR_ACTIVATION: SFR_RDATA <= activation_reg;
        default: SFR_RDATA <= serial_pkg::RESET_BYTE; // unmapped reads zero
      endcase
    end
  end
endmodule : dual_serial_timer
`default_nettype wire

// ### verilog/rx_sampler.sv
`timescale 1ns/1ns
`default_nettype none
module rx_sampler (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  input wire logic tick,
  output logic level,
  output logic majority
);
  logic meta_reg;
  logic [2:0] samples_reg;

  // two-stage synchroniser; idle line is high
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      meta_reg <= pin;
      level <= meta_reg;
    end
  end

  // three most recent oversamples
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      samples_reg <= 3'b111;
    else if (tick)
      samples_reg <= {samples_reg[1:0], level};
  end

  // noise rejection: two of three wins
  assign majority = (samples_reg[0] & samples_reg[1]) | (samples_reg[0] & samples_reg[2])
                  | (samples_reg[1] & samples_reg[2]);
endmodule : rx_sampler
`default_nettype wire

// ### verilog/sync_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  fifo_if.sink fill,
  fifo_if.source drain
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : bad_shape
    $error("sync_fifo needs a power-of-two depth of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign fill.ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign drain.valid = wr_ptr_reg != rd_ptr_reg;
  assign drain.data = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // storage, written only on an accepted push
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg[AW-1:0]] <= fill.data;
  end

  // pointers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : sync_fifo
`default_nettype wire
